// ---- hdl/icu_ctrl.sv ----
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module icu_ctrl
    import icu_pkg::*;
(
    // Clock, reset and standby.
    input  wire logic                CLK_IN,
    input  wire logic                SRST_IN,
    input  wire logic                STANDBY_IN,
    // Request pins and peripheral requests.
    input  wire logic                NMI_PIN_IN,
    input  wire logic [NUM_PINS-1:0] IRQ_PIN_N_IN,
    input  wire logic [NUM_VEC-1:0]  PERIPH_REQ_IN,
    // APB slave.
    input  wire logic                PSEL_IN,
    input  wire logic                PENABLE_IN,
    input  wire logic                PWRITE_IN,
    input  wire logic [7:0]          PADDR_IN,
    input  wire logic [31:0]         PWDATA_IN,
    output logic [31:0]              PRDATA_OUT,
    output logic                     PREADY_OUT,
    output logic                     PSLVERR_OUT,
    // Link to the CPU core.
    icu_if.ctrl                      CPU_LINK
);
    logic [7:0]          priority_reg_a;
    logic [7:0]          priority_reg_b;
    logic [7:0]          system_control_reg;
    logic [NUM_VEC-1:0]  enable;
    logic [NUM_PINS:0]   s1;
    logic [NUM_PINS:0]   s2;
    logic [NUM_PINS:0]   s3;
    logic [NUM_PINS:0]   stable;
    logic                nmi_prev;
    logic                nmi_pend;
    logic                req;
    logic [VEC_W-1:0]    vec;
    logic [NUM_VEC-1:0]  raw_req;
    logic [NUM_VEC-1:0]  lvl;
    logic [NUM_VEC-1:0]  allowed;
    logic                allow1;
    logic                allow0;
    logic                found;
    logic [VEC_W-1:0]    pick;

    wire logic mode_single = system_control_reg[SYS_MODE_BIT];
    wire logic nmi_now     = stable[NUM_PINS];
    wire logic nmi_edge    = system_control_reg[SYS_NMI_EDGE] ? (nmi_now & ~nmi_prev)
                                                              : (~nmi_now & nmi_prev);
    wire logic nmi_taken   = CPU_LINK.ack && vec == VEC_NMI;
    wire logic setup       = PSEL_IN && !PENABLE_IN;
    wire logic wr_access   = PSEL_IN && PENABLE_IN && PWRITE_IN;
    wire logic addr_ok     = PADDR_IN == OFF_PRIO_A || PADDR_IN == OFF_PRIO_B ||
                             PADDR_IN == OFF_SYSCTL || PADDR_IN == OFF_EN_LO ||
                             PADDR_IN == OFF_EN_HI  || PADDR_IN == OFF_STATUS;

    // Pins pass three flops; a level counts once the last two agree.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            s1     <= '1;
            s2     <= '1;
            s3     <= '1;
            stable <= '1;
        end else begin
            s1     <= {NMI_PIN_IN, IRQ_PIN_N_IN};
            s2     <= s1;
            s3     <= s2;
            stable <= (s2 ~^ s3) & s2 | ~(s2 ~^ s3) & stable;
        end
    end

    // Request and level vectors, one slot per vector number.
    genvar g;
    generate
        for (g = 0; g < NUM_VEC; g++) begin : g_src
            if (g >= VEC_PIN0 && g < VEC_PIN0 + NUM_PINS) begin : g_pin
                assign raw_req[g] = ~stable[g - VEC_PIN0];
            end else begin : g_per
                assign raw_req[g] = PERIPH_REQ_IN[g];
            end
            assign lvl[g]     = icu_prio_of(g, priority_reg_a, priority_reg_b);
            assign allowed[g] = raw_req[g] & enable[g] & icu_src_used(g) &
                                (lvl[g] ? allow1 : allow0);
        end
    endgenerate

    // Level 0 needs the primary mask clear; level 1 also passes with only
    // the primary set in three-level mode.
    assign allow0 = !CPU_LINK.mask_i;
    assign allow1 = !CPU_LINK.mask_i || (!mode_single && !CPU_LINK.mask_ui);

    icu_pick #(
        .N (NUM_VEC)
    ) u_pick (
        .req_in    (allowed),
        .lvl_in    (lvl),
        .found_out (found),
        .idx_out   (pick)
    );

    // A new edge in the acknowledge cycle keeps the flag set.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            nmi_prev <= 1'b1;
            nmi_pend <= 1'b0;
        end else if (STANDBY_IN) begin
            nmi_prev <= nmi_now;
            nmi_pend <= 1'b0;
        end else begin
            nmi_prev <= nmi_now;
            nmi_pend <= nmi_edge | (nmi_pend & ~nmi_taken);
        end
    end

    // The offered request is registered; after an acknowledge it drops for
    // one cycle so the CPU never sees the old vector twice.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || STANDBY_IN) begin
            req <= 1'b0;
            vec <= '0;
        end else if (CPU_LINK.ack) begin
            req <= 1'b0;
        end else if (nmi_pend) begin
            req <= 1'b1;
            vec <= VEC_NMI;
        end else begin
            req <= found;
            vec <= pick;
        end
    end

    assign CPU_LINK.req         = req;
    assign CPU_LINK.vec         = vec;
    assign CPU_LINK.mode_single = mode_single;

    // Register writes take effect in the access phase.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            priority_reg_a     <= PRIO_RESET;
            priority_reg_b     <= PRIO_RESET;
            system_control_reg <= SYSCTL_RESET;
            enable             <= {EN_RESET, EN_RESET};
        end else if (wr_access) begin
            case (PADDR_IN)
                OFF_PRIO_A: priority_reg_a     <= PWDATA_IN[7:0];
                OFF_PRIO_B: priority_reg_b     <= PWDATA_IN[7:0];
                OFF_SYSCTL: system_control_reg <= PWDATA_IN[7:0];
                OFF_EN_LO:  enable[31:0]       <= PWDATA_IN;
                OFF_EN_HI:  enable[63:32]      <= PWDATA_IN;
                default:    ;
            endcase
        end
    end

    // Read data is captured in the setup cycle, so it is stable in access.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            PRDATA_OUT  <= '0;
            PSLVERR_OUT <= 1'b0;
        end else if (setup) begin
            PSLVERR_OUT <= !addr_ok;
            case (PADDR_IN)
                OFF_PRIO_A: PRDATA_OUT <= {24'h00_0000, priority_reg_a};
                OFF_PRIO_B: PRDATA_OUT <= {24'h00_0000, priority_reg_b};
                OFF_SYSCTL: PRDATA_OUT <= {24'h00_0000, system_control_reg};
                OFF_EN_LO:  PRDATA_OUT <= enable[31:0];
                OFF_EN_HI:  PRDATA_OUT <= enable[63:32];
                OFF_STATUS: PRDATA_OUT <= {22'h00_0000, nmi_pend, req, 2'h0, vec};
                default:    PRDATA_OUT <= '0;
            endcase
        end
    end

    assign PREADY_OUT = 1'b1;
endmodule
`default_nettype wire

// ---- hdl/icu_pkg.sv ----
package icu_pkg;

    localparam int VEC_W      = 6;
    localparam int NUM_VEC    = 64;
    localparam int NUM_PINS   = 6;
    localparam int ADDR_W     = 24;
    localparam int SLOT_SHIFT = 2;

    localparam logic [5:0] VEC_NMI   = 6'h07;
    localparam logic [5:0] VEC_PIN0  = 6'h0c;
    localparam logic [5:0] VEC_SER0  = 6'h34;
    localparam logic [5:0] VEC_SER1  = 6'h38;
    localparam logic [5:0] VEC_SER2  = 6'h3c;

    localparam logic [7:0] OFF_PRIO_A = 8'h00;
    localparam logic [7:0] OFF_PRIO_B = 8'h04;
    localparam logic [7:0] OFF_SYSCTL = 8'h08;
    localparam logic [7:0] OFF_EN_LO  = 8'h0c;
    localparam logic [7:0] OFF_EN_HI  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    localparam int SYS_MODE_BIT = 3;
    localparam int SYS_NMI_EDGE = 2;
    localparam int CCR_I_BIT    = 7;
    localparam int CCR_UI_BIT   = 6;

    localparam logic [7:0]  PRIO_RESET   = 8'h00;
    localparam logic [7:0]  SYSCTL_RESET = 8'h08;
    localparam logic [31:0] EN_RESET     = 32'h0000_0000;
    localparam logic [7:0]  CCR_RESET    = 8'h80;
    localparam logic [7:0]  VEC_ADDR_HI  = 8'h00;

    // Priority bit of the group that a vector belongs to.
    function automatic logic icu_prio_of(input int v, input logic [7:0] a,
                                         input logic [7:0] b);
        logic r;
        r = 1'b0;
        if (v == 12) r = a[7];
        else if (v == 13) r = a[6];
        else if (v >= 14 && v <= 15) r = a[5];
        else if (v >= 16 && v <= 17) r = a[4];
        else if (v >= 20 && v <= 35) r = a[3 - (v - 20) / 4];
        else if (v >= 36 && v <= 47) r = b[7 - (v - 36) / 4];
        else if (v >= 52 && v <= 63) r = b[3 - (v - 52) / 4];
        return r;
    endfunction

    // Vectors that carry a real source; reserved slots never request.
    function automatic logic icu_src_used(input int v);
        logic r;
        r = 1'b0;
        if (v >= 12 && v <= 17) r = 1'b1;
        else if (v >= 20 && v <= 47) r = (v != 22) && (v % 4 != 3 || v >= 36 || v == 23);
        else if (v >= 52 && v <= 63) r = 1'b1;
        return r;
    endfunction

endpackage

// ---- hdl/icu_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface icu_if;
    import icu_pkg::*;
    logic             req;
    logic [VEC_W-1:0] vec;
    logic             mode_single;
    logic             ack;
    logic             mask_i;
    logic             mask_ui;

    modport ctrl (output req, output vec, output mode_single,
                  input ack, input mask_i, input mask_ui);
    modport cpu  (input req, input vec, input mode_single,
                  output ack, output mask_i, output mask_ui);
endinterface
`default_nettype wire

// ---- hdl/icu_pick.sv ----
`timescale 1ns/10ps
`default_nettype none
module icu_pick #(
    parameter int N = 64
) (
    input  wire logic [N-1:0]         req_in,
    input  wire logic [N-1:0]         lvl_in,
    output logic                      found_out,
    output logic [$clog2(N)-1:0]      idx_out
);
    logic [N-1:0] hi;
    assign hi = req_in & lvl_in;

    // Scanning downwards lets the smallest index overwrite last.
    always_comb begin
        found_out = 1'b0;
        idx_out   = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req_in[k] && !(|hi)) begin
                found_out = 1'b1;
                idx_out   = $clog2(N)'(k);
            end
        end
        for (int k = N - 1; k >= 0; k--) begin
            if (hi[k]) begin
                found_out = 1'b1;
                idx_out   = $clog2(N)'(k);
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/icu_cpu_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module icu_cpu_end
    import icu_pkg::*;
(
    // Clock and reset.
    input  wire logic              CLK_IN,
    input  wire logic              SRST_IN,
    // Instruction stream.
    input  wire logic              INSTR_DONE_IN,
    input  wire logic [ADDR_W-1:0] NEXT_PC_IN,
    input  wire logic              CCR_WR_IN,
    input  wire logic [7:0]        CCR_WDATA_IN,
    output logic [7:0]             CCR_OUT,
    // Stack and vector access.
    output logic                   STACK_PUSH_OUT,
    output logic [31:0]            STACK_DATA_OUT,
    output logic                   VEC_FETCH_OUT,
    output logic [ADDR_W-1:0]      VEC_ADDR_OUT,
    input  wire logic              VEC_VALID_IN,
    input  wire logic [ADDR_W-1:0] VEC_DATA_IN,
    output logic                   PC_LOAD_OUT,
    output logic [ADDR_W-1:0]      PC_NEW_OUT,
    output logic                   BUSY_OUT,
    // Link to the controller.
    icu_if.cpu                     CTRL_LINK
);
    typedef enum {ICU_IDLE, ICU_PUSH_PC, ICU_PUSH_CCR, ICU_FETCH, ICU_JUMP} icu_state_t;

    icu_state_t        state;
    icu_state_t        next_state;
    logic [7:0]        cpu_condition_reg;
    logic [ADDR_W-1:0] saved_pc;
    logic [VEC_W-1:0]  taken_vec;

    wire logic accept = state == ICU_IDLE && CTRL_LINK.req && INSTR_DONE_IN;

    always_comb begin
        next_state = state;
        case (state)
            ICU_IDLE:     if (accept) next_state = ICU_PUSH_PC;
            ICU_PUSH_PC:  next_state = ICU_PUSH_CCR;
            ICU_PUSH_CCR: next_state = ICU_FETCH;
            ICU_FETCH:    if (VEC_VALID_IN) next_state = ICU_JUMP;
            ICU_JUMP:     next_state = ICU_IDLE;
            default:      next_state = ICU_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state     <= ICU_IDLE;
            saved_pc  <= '0;
            taken_vec <= '0;
        end else begin
            state <= next_state;
            if (accept) begin
                saved_pc  <= NEXT_PC_IN;
                taken_vec <= CTRL_LINK.vec;
            end
        end
    end

    // Masks are raised only once both words are on the stack.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            cpu_condition_reg <= CCR_RESET;
        end else if (state == ICU_PUSH_CCR) begin
            cpu_condition_reg[CCR_I_BIT] <= 1'b1;
            if (!CTRL_LINK.mode_single) begin
                cpu_condition_reg[CCR_UI_BIT] <= 1'b1;
            end
        end else if (CCR_WR_IN && state == ICU_IDLE) begin
            cpu_condition_reg <= CCR_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            STACK_PUSH_OUT <= 1'b0;
            STACK_DATA_OUT <= '0;
            VEC_FETCH_OUT  <= 1'b0;
            VEC_ADDR_OUT   <= '0;
            PC_LOAD_OUT    <= 1'b0;
            PC_NEW_OUT     <= '0;
        end else begin
            STACK_PUSH_OUT <= next_state == ICU_PUSH_PC || next_state == ICU_PUSH_CCR;
            STACK_DATA_OUT <= (next_state == ICU_PUSH_PC) ? {8'h00, NEXT_PC_IN}
                                                          : {24'h00_0000, cpu_condition_reg};
            VEC_FETCH_OUT  <= next_state == ICU_FETCH;
            VEC_ADDR_OUT   <= {VEC_ADDR_HI, 8'h00, taken_vec, 2'b00};
            PC_LOAD_OUT    <= state == ICU_FETCH && VEC_VALID_IN;
            if (state == ICU_FETCH && VEC_VALID_IN) begin
                PC_NEW_OUT <= VEC_DATA_IN;
            end
        end
    end

    assign CTRL_LINK.ack     = accept;
    assign CTRL_LINK.mask_i  = cpu_condition_reg[CCR_I_BIT];
    assign CTRL_LINK.mask_ui = cpu_condition_reg[CCR_UI_BIT];
    assign CCR_OUT           = cpu_condition_reg;
    assign BUSY_OUT          = state != ICU_IDLE;
endmodule
`default_nettype wire

// ---- tb/icu_link_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module icu_link_properties
    import icu_pkg::*;
(
    // Clock and reset.
    input  wire logic             CLK_IN,
    input  wire logic             SRST_IN,
    // Link signals.
    input  wire logic             req,
    input  wire logic [VEC_W-1:0] vec,
    input  wire logic             mode_single,
    input  wire logic             ack,
    input  wire logic             mask_i,
    input  wire logic             mask_ui
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SRST_IN);

    // The core stays off the link while it stacks and fetches.
    sequence s_busy;
        !ack [*4];
    endsequence
    sequence s_masked;
        ##[1:4] mask_i;
    endsequence

    ack_has_req_a: assert property (ack |-> req)
        else $error("ack without a request");
    req_drops_a: assert property (ack |=> !req)
        else $error("request stays after ack");
    entry_busy_a: assert property (ack |=> s_busy)
        else $error("ack during exception entry");
    single_mask_a: assert property (ack && mode_single |-> s_masked)
        else $error("primary mask not set by entry");
    both_masks_a: assert property (ack && !mode_single |-> ##[1:4] (mask_i && mask_ui))
        else $error("masks not both set by entry");
    single_block_a: assert property (
        req && $past(mask_i) && $past(mode_single) |-> vec == VEC_NMI)
        else $error("maskable request offered while masked");
    both_block_a: assert property (
        req && $past(mask_i) && $past(mask_ui) && !$past(mode_single) |-> vec == VEC_NMI)
        else $error("request offered with both masks set");
    vec_legal_a: assert property (req |-> vec == VEC_NMI || vec >= VEC_PIN0)
        else $error("request with a vector that has no source");
    reset_state_a: assert property (
        $fell(SRST_IN) |-> !req && mode_single && mask_i && !mask_ui)
        else $error("link not in its reset state");
endmodule
`default_nettype wire

// ---- tb/tb_two_level_priority_interrupt_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_two_level_priority_interrupt_ctrl
    import icu_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        standby = 1'b0;
    logic        nmi = 1'b1;
    logic [5:0]  irq_n = 6'h3f;
    logic [63:0] periph = 64'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        instr_done = 1'b0;
    logic [23:0] next_pc = 24'h0;
    logic        ccr_wr = 1'b0;
    logic [7:0]  ccr_wdata = 8'h00;
    logic [7:0]  ccr_out;
    logic        push;
    logic [31:0] push_data;
    logic        fetch;
    logic [23:0] fetch_addr;
    logic        vec_valid = 1'b0;
    logic [23:0] vec_data = 24'h0;
    logic        pc_load;
    logic [23:0] pc_new;
    logic        busy;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    icu_if link();
    icu_ctrl u_icu_ctrl (.CLK_IN(clk), .SRST_IN(srst), .STANDBY_IN(standby),
        .NMI_PIN_IN(nmi), .IRQ_PIN_N_IN(irq_n), .PERIPH_REQ_IN(periph),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .CPU_LINK(link));
    icu_cpu_end u_icu_cpu_end (.CLK_IN(clk), .SRST_IN(srst), .INSTR_DONE_IN(instr_done),
        .NEXT_PC_IN(next_pc), .CCR_WR_IN(ccr_wr), .CCR_WDATA_IN(ccr_wdata),
        .CCR_OUT(ccr_out), .STACK_PUSH_OUT(push), .STACK_DATA_OUT(push_data),
        .VEC_FETCH_OUT(fetch), .VEC_ADDR_OUT(fetch_addr), .VEC_VALID_IN(vec_valid),
        .VEC_DATA_IN(vec_data), .PC_LOAD_OUT(pc_load), .PC_NEW_OUT(pc_new),
        .BUSY_OUT(busy), .CTRL_LINK(link));
    icu_link_properties u_icu_link_properties (.CLK_IN(clk), .SRST_IN(srst),
        .req(link.req), .vec(link.vec), .mode_single(link.mode_single), .ack(link.ack),
        .mask_i(link.mask_i), .mask_ui(link.mask_ui));

    always #2.5 clk = ~clk;

    // Vector memory answers one cycle late; between answers its data keeps toggling.
    always @(posedge clk) begin
        vec_valid <= fetch;
        vec_data  <= fetch ? ~fetch_addr : ~vec_data;
        cycles    <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic set_ccr(input logic [7:0] c);
        ccr_wr    <= 1'b1;
        ccr_wdata <= c;
        @(posedge clk);
        ccr_wr <= 1'b0;
        @(posedge clk);
    endtask

    // Lets the request settle with no instruction boundary, then offers one.
    task automatic take(input logic [5:0] v, input logic [7:0] c, input logic ui);
        int          n;
        logic [31:0] p[2];
        logic [23:0] va;
        logic [23:0] pn;
        logic [23:0] ea;
        n = 0;
        ea = {VEC_ADDR_HI, 8'h00, v, 2'b00};
        next_pc <= {18'h1a5, v};
        repeat (6) begin
            @(posedge clk);
            if (link.ack === 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        chk(32'(busy), 32'h0);
        n = 0;
        instr_done <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (link.ack !== 1'b1 && n < 40);
        instr_done <= 1'b0;
        chk({26'h0, link.vec}, {26'h0, v});
        n = 0;
        repeat (12) begin
            @(posedge clk);
            if (push === 1'b1 && n < 2) begin
                p[n] = push_data;
                n++;
            end
            if (fetch === 1'b1) va = fetch_addr;
            if (pc_load === 1'b1) pn = pc_new;
        end
        chk({8'h0, p[0][23:0]}, {8'h0, 18'h1a5, v});
        chk({24'h0, p[1][7:0]}, {24'h0, c});
        chk({8'h0, va}, {8'h0, ea});
        chk({8'h0, pn}, {8'h0, ~ea});
        chk({30'h0, ccr_out[7:6]}, {30'h0, 1'b1, ui});
    endtask

    task automatic none();
        int n;
        n = 0;
        instr_done <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            if (link.ack === 1'b1) n++;
        end
        instr_done <= 1'b0;
        @(posedge clk);
        chk(32'(n), 32'h0);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, OFF_SYSCTL, 32'h0, r, e);
        chk(r, {24'h0, SYSCTL_RESET});
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h0);
        apb(1'b1, OFF_PRIO_A, 32'h20, r, e);
        apb(1'b0, OFF_PRIO_A, 32'h0, r, e);
        chk(r, 32'h20);
        wr(OFF_PRIO_A, 32'h0);
        $display("done regs");
    endtask

    task automatic t_serial();
        wr(OFF_EN_HI, 32'hfff0_0000);
        for (int v = 52; v < 64; v++) begin
            periph <= 64'h1 << v;
            set_ccr(8'h00);
            take(6'(v), 8'h00, 1'b0);
        end
        periph <= (64'h1 << 53) | (64'h1 << 58);
        wr(OFF_PRIO_B, 32'h4);
        set_ccr(8'h00);
        take(6'd58, 8'h00, 1'b0);
        wr(OFF_PRIO_B, 32'h0);
        set_ccr(8'h00);
        take(6'd53, 8'h00, 1'b0);
        periph <= 64'h0;
        $display("done serial");
    endtask

    task automatic t_enable();
        wr(OFF_EN_HI, 32'h0);
        periph <= 64'h1 << 52;
        set_ccr(8'h00);
        none();
        wr(OFF_EN_HI, 32'h0010_0000);
        take(6'd52, 8'h00, 1'b0);
        periph <= 64'h0;
        $display("done enable");
    endtask

    task automatic t_three();
        wr(OFF_SYSCTL, 32'h0);
        wr(OFF_PRIO_A, 32'h20);
        wr(OFF_EN_LO, 32'h0003_f000);
        irq_n <= 6'b111010;
        set_ccr(8'h80);
        take(6'd14, 8'h80, 1'b1);
        irq_n <= 6'b111110;
        repeat (6) @(posedge clk);
        set_ccr(8'h80);
        none();
        set_ccr(8'hc0);
        irq_n <= 6'b111010;
        none();
        set_ccr(8'h40);
        take(6'd14, 8'h40, 1'b1);
        wr(OFF_PRIO_A, 32'h0);
        set_ccr(8'h00);
        take(6'd12, 8'h00, 1'b1);
        wr(OFF_SYSCTL, {24'h0, SYSCTL_RESET});
        $display("done three level");
    endtask

    task automatic t_nmi();
        irq_n <= 6'b111110;
        set_ccr(8'h80);
        none();
        nmi <= 1'b0;
        take(6'd7, 8'h80, 1'b0);
        nmi <= 1'b1;
        none();
        irq_n <= 6'h3f;
        $display("done nmi");
    endtask

    // An edge that falls inside standby is lost; one after it is taken.
    task automatic t_standby();
        standby <= 1'b1;
        nmi     <= 1'b0;
        none();
        standby <= 1'b0;
        none();
        nmi <= 1'b1;
        repeat (6) @(posedge clk);
        nmi <= 1'b0;
        take(6'd7, 8'h80, 1'b0);
        nmi <= 1'b1;
        $display("done standby");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_serial();
        t_enable();
        t_three();
        t_nmi();
        t_standby();
        stop_test();
    end
endmodule
`default_nettype wire
